// ===== design/spc_pkg.sv
// Shared constants, types and register layout for the standby power control block.
package spc_pkg;

  // ****************************************************************
  // Register addresses
  // ****************************************************************
  localparam logic [15:0] SYSCTL_ADDR = 16'hfff2;
  localparam logic [15:0] MODSTOP_ADDR = 16'hff5e;
  localparam logic [15:0] DIVCTL_ADDR = 16'hff5d;
  localparam logic [15:0] STATUS_ADDR = 16'hff5c;

  // ****************************************************************
  // Reset values, writable masks and fixed bits
  // ****************************************************************
  localparam logic [7:0] SYSCTL_RESET = 8'h0b;
  localparam logic [7:0] SYSCTL_WMASK = 8'hf5;
  localparam logic [7:0] MODSTOP_RESET = 8'h40;
  localparam logic [7:0] MODSTOP_WMASK = 8'hb9;
  localparam logic [7:0] DIVCTL_RESET = 8'h00;
  localparam logic [7:0] DIVCTL_WMASK = 8'h03;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;
  localparam logic [7:0] STOPPED_PERIPH_DATA = 8'hff;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int SYS_SOFT_STANDBY_BIT = 7;
  localparam int SYS_SETTLE_LSB = 4;
  localparam int SYS_NMI_EDGE_BIT = 2;
  localparam int SYS_RAM_ENABLE_BIT = 0;
  localparam int MOD_CLKOUT_STOP_BIT = 7;
  localparam int MOD_TIMER_BIT = 5;
  localparam int MOD_SERIAL0_BIT = 4;
  localparam int MOD_SERIAL1_BIT = 3;
  localparam int MOD_ADC_BIT = 0;
  localparam int DIV_SELECT_LSB = 0;
  localparam int MOD_STOP_COUNT = 4;

  // ****************************************************************
  // Settling wait in prescaled states, per select code
  // ****************************************************************
  localparam int SETTLE_STATES_0 = 8192;
  localparam int SETTLE_STATES_1 = 16384;
  localparam int SETTLE_STATES_2 = 32768;
  localparam int SETTLE_STATES_3 = 65536;
  localparam int SETTLE_STATES_4 = 131072;
  localparam int SETTLE_STATES_5 = 1024;
  localparam int SETTLE_COUNT_WIDTH = 21;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [5:0] {
    SPC_RUN = 6'h01,
    SPC_SLEEP = 6'h02,
    SPC_SW_STANDBY_PIN = 6'h04,
    SPC_SETTLE = 6'h08,
    SPC_HW_STANDBY_PIN = 6'h10,
    SPC_RESET = 6'h20
  } spc_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } spc_bus_req_t;

endpackage : spc_pkg

// ===== design/spc_settle_timer.sv
// Oscillator settling timer counting prescaled states after a wake-up request.
`timescale 1ns/100ps
module spc_settle_timer #(
  parameter int CW = spc_pkg::SETTLE_COUNT_WIDTH,
  parameter int WAIT_0 = spc_pkg::SETTLE_STATES_0,
  parameter int WAIT_1 = spc_pkg::SETTLE_STATES_1,
  parameter int WAIT_2 = spc_pkg::SETTLE_STATES_2,
  parameter int WAIT_3 = spc_pkg::SETTLE_STATES_3,
  parameter int WAIT_4 = spc_pkg::SETTLE_STATES_4,
  parameter int WAIT_5 = spc_pkg::SETTLE_STATES_5
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic abort,
  input wire logic start,
  input wire logic [2:0] settle_wait_select,
  input wire logic [1:0] clock_divider_select,
  output logic done
);

  logic [CW-1:0] count;
  logic busy;

  // Illegal codes take the longest wait, so a bad setting errs on the safe side.
  function automatic logic [CW-1:0] settle_cycles(input logic [2:0] sel, input logic [1:0] div);
    logic [CW-1:0] base;
    base = CW'(WAIT_4);
    case (sel)
      3'h0: base = CW'(WAIT_0);
      3'h1: base = CW'(WAIT_1);
      3'h2: base = CW'(WAIT_2);
      3'h3: base = CW'(WAIT_3);
      3'h4: base = CW'(WAIT_4);
      3'h5: base = CW'(WAIT_5);
      default: base = CW'(WAIT_4);
    endcase
    settle_cycles = base << div;
  endfunction : settle_cycles

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      if (abort) begin
        busy <= 1'b0;
      end else if (start) begin
        count <= settle_cycles(settle_wait_select, clock_divider_select) - CW'(1);
        busy <= 1'b1;
      end else if (busy) begin
        if (count == '0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - CW'(1);
        end
      end
    end
  end

endmodule : spc_settle_timer

// ===== design/spc_standby_power_control.sv
// Power-down sequencer: software standby, hardware standby, module standby, clock output.
`timescale 1ns/100ps
module spc_standby_power_control #(
  parameter int WAIT_0 = spc_pkg::SETTLE_STATES_0,
  parameter int WAIT_1 = spc_pkg::SETTLE_STATES_1,
  parameter int WAIT_2 = spc_pkg::SETTLE_STATES_2,
  parameter int WAIT_3 = spc_pkg::SETTLE_STATES_3,
  parameter int WAIT_4 = spc_pkg::SETTLE_STATES_4,
  parameter int WAIT_5 = spc_pkg::SETTLE_STATES_5
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire spc_pkg::spc_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  input wire logic reset_pin_b,
  input wire logic standby_pin_b,
  input wire logic nmi_pin,
  input wire logic ext_request_0_b,
  input wire logic ext_request_1_b,
  input wire logic [2:0] operating_mode_pins,
  input wire logic halt_request,
  input wire logic [1:0] irq_enable,
  input wire logic irq_masked,
  input wire logic sleep_wake_request,
  input wire logic [3:0] periph_hit,
  output spc_pkg::spc_state_t power_state,
  output logic osc_enable,
  output logic clock_supply,
  output logic cpu_halt,
  output logic chip_reset,
  output logic int_exception,
  output logic reset_exception,
  output logic port_hold,
  output logic port_hiz,
  output logic ram_enable,
  output logic [3:0] module_standby,
  output logic [3:0] module_init,
  output logic clkout_o,
  output logic clkout_oe,
  output logic [2:0] mode_latched
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;
  logic nmi_prev;
  logic res_s;
  logic standby_pin_s;
  logic nmi_s;
  logic ext_request_0_s;
  logic ext_request_1_s;
  logic [2:0] mode_s;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta <= 8'h1f;
      pin_sync <= 8'h1f;
    end else if (clk_en) begin
      pin_meta <= {operating_mode_pins, ext_request_1_b, ext_request_0_b, nmi_pin,
                   standby_pin_b, reset_pin_b};
      pin_sync <= pin_meta;
    end
  end

  assign res_s = pin_sync[0];
  assign standby_pin_s = pin_sync[1];
  assign nmi_s = pin_sync[2];
  assign ext_request_0_s = pin_sync[3];
  assign ext_request_1_s = pin_sync[4];
  assign mode_s = pin_sync[7:5];

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      nmi_prev <= 1'b1;
    end else if (clk_en) begin
      nmi_prev <= nmi_s;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] system_control_reg;
  logic [7:0] module_stop_control_reg;
  logic [7:0] divider_control_reg;
  spc_pkg::spc_state_t state;
  spc_pkg::spc_state_t next_state;
  logic soft_standby_select;
  logic nmi_edge_select;
  logic clock_output_stop;
  logic [2:0] settle_wait_select;
  logic [1:0] clock_divider_select;
  logic [3:0] stop_bits;
  logic [3:0] new_stop_bits;
  logic reg_init;
  logic wr_sys;
  logic wr_mod;
  logic wr_div;

  assign soft_standby_select = system_control_reg[spc_pkg::SYS_SOFT_STANDBY_BIT];
  assign nmi_edge_select = system_control_reg[spc_pkg::SYS_NMI_EDGE_BIT];
  assign settle_wait_select = system_control_reg[spc_pkg::SYS_SETTLE_LSB +: 3];
  assign clock_divider_select = divider_control_reg[spc_pkg::DIV_SELECT_LSB +: 2];
  assign clock_output_stop = module_stop_control_reg[spc_pkg::MOD_CLKOUT_STOP_BIT];
  assign stop_bits = {module_stop_control_reg[spc_pkg::MOD_TIMER_BIT],
                      module_stop_control_reg[spc_pkg::MOD_SERIAL0_BIT],
                      module_stop_control_reg[spc_pkg::MOD_SERIAL1_BIT],
                      module_stop_control_reg[spc_pkg::MOD_ADC_BIT]};
  assign new_stop_bits = {bus_req.wdata[spc_pkg::MOD_TIMER_BIT],
                          bus_req.wdata[spc_pkg::MOD_SERIAL0_BIT],
                          bus_req.wdata[spc_pkg::MOD_SERIAL1_BIT],
                          bus_req.wdata[spc_pkg::MOD_ADC_BIT]};
  assign reg_init = (next_state == spc_pkg::SPC_HW_STANDBY_PIN) || (next_state == spc_pkg::SPC_RESET);
  assign wr_sys = bus_req.wr && (bus_req.addr == spc_pkg::SYSCTL_ADDR);
  assign wr_mod = bus_req.wr && (bus_req.addr == spc_pkg::MODSTOP_ADDR);
  assign wr_div = bus_req.wr && (bus_req.addr == spc_pkg::DIVCTL_ADDR);

  // Registers take their initial values while reset or hardware standby holds the chip.
  // The standby select bit is changed only by a write or a register reset, never by a wake-up.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      system_control_reg <= spc_pkg::SYSCTL_RESET;
      module_stop_control_reg <= spc_pkg::MODSTOP_RESET;
      divider_control_reg <= spc_pkg::DIVCTL_RESET;
    end else if (clk_en) begin
      if (reg_init) begin
        system_control_reg <= spc_pkg::SYSCTL_RESET;
        module_stop_control_reg <= spc_pkg::MODSTOP_RESET;
        divider_control_reg <= spc_pkg::DIVCTL_RESET;
      end else begin
        if (wr_sys) begin
          system_control_reg <= (bus_req.wdata & spc_pkg::SYSCTL_WMASK) |
                                (spc_pkg::SYSCTL_RESET & ~spc_pkg::SYSCTL_WMASK);
        end
        if (wr_mod) begin
          module_stop_control_reg <= (bus_req.wdata & spc_pkg::MODSTOP_WMASK) |
                                     (spc_pkg::MODSTOP_RESET & ~spc_pkg::MODSTOP_WMASK);
        end
        if (wr_div) begin
          divider_control_reg <= bus_req.wdata & spc_pkg::DIVCTL_WMASK;
        end
      end
    end
  end

  // Peripherals see the stop bits straight from the register, so a halt takes effect
  // in the bus cycle after the write and reads from them return STOPPED_PERIPH_DATA from then on.
  assign module_standby = stop_bits;
  assign ram_enable = system_control_reg[spc_pkg::SYS_RAM_ENABLE_BIT];

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      module_init <= 4'hf;
    end else if (clk_en) begin
      if (reg_init) begin
        module_init <= 4'hf;
      end else if (wr_mod) begin
        module_init <= new_stop_bits & ~stop_bits;
      end else begin
        module_init <= 4'h0;
      end
    end
  end

  // ****************************************************************
  // Register read port
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_rdata <= spc_pkg::UNMAPPED_DATA;
    end else if (clk_en) begin
      if (bus_req.rd) begin
        if (|(periph_hit & stop_bits)) begin
          bus_rdata <= spc_pkg::STOPPED_PERIPH_DATA;
        end else begin
          case (bus_req.addr)
            spc_pkg::SYSCTL_ADDR: bus_rdata <= system_control_reg;
            spc_pkg::MODSTOP_ADDR: bus_rdata <= module_stop_control_reg;
            spc_pkg::DIVCTL_ADDR: bus_rdata <= divider_control_reg;
            spc_pkg::STATUS_ADDR: bus_rdata <= {2'h0, state};
            default: bus_rdata <= spc_pkg::UNMAPPED_DATA;
          endcase
        end
      end else begin
        bus_rdata <= spc_pkg::UNMAPPED_DATA;
      end
    end
  end

  // ****************************************************************
  // Power state machine
  // ****************************************************************
  logic nmi_edge;
  logic irq_wake;
  logic settle_start;
  logic settle_done;

  assign nmi_edge = nmi_edge_select ? (nmi_s && !nmi_prev) : (!nmi_s && nmi_prev);
  assign irq_wake = !irq_masked &&
                    ((irq_enable[0] && !ext_request_0_s) || (irq_enable[1] && !ext_request_1_s));
  assign settle_start = (state == spc_pkg::SPC_SW_STANDBY_PIN) && (next_state == spc_pkg::SPC_SETTLE);

  always_comb begin
    next_state = state;
    if (!standby_pin_s) begin
      next_state = spc_pkg::SPC_HW_STANDBY_PIN;
    end else if (!res_s) begin
      next_state = spc_pkg::SPC_RESET;
    end else begin
      case (state)
        spc_pkg::SPC_RUN: begin
          if (halt_request) begin
            next_state = soft_standby_select ? spc_pkg::SPC_SW_STANDBY_PIN
                                             : spc_pkg::SPC_SLEEP;
          end
        end
        spc_pkg::SPC_SLEEP: begin
          if (sleep_wake_request || nmi_edge || irq_wake) begin
            next_state = spc_pkg::SPC_RUN;
          end
        end
        spc_pkg::SPC_SW_STANDBY_PIN: begin
          if (nmi_edge || irq_wake) begin
            next_state = spc_pkg::SPC_SETTLE;
          end
        end
        spc_pkg::SPC_SETTLE: begin
          if (settle_done) begin
            next_state = spc_pkg::SPC_RUN;
          end
        end
        spc_pkg::SPC_HW_STANDBY_PIN: next_state = spc_pkg::SPC_RESET;
        spc_pkg::SPC_RESET: next_state = spc_pkg::SPC_RUN;
        default: next_state = spc_pkg::SPC_RESET;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= spc_pkg::SPC_RESET;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  spc_settle_timer #(
    .CW(spc_pkg::SETTLE_COUNT_WIDTH),
    .WAIT_0(WAIT_0),
    .WAIT_1(WAIT_1),
    .WAIT_2(WAIT_2),
    .WAIT_3(WAIT_3),
    .WAIT_4(WAIT_4),
    .WAIT_5(WAIT_5)
  ) u_settle (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .abort(state != spc_pkg::SPC_SETTLE && !settle_start),
    .start(settle_start),
    .settle_wait_select(settle_wait_select),
    .clock_divider_select(clock_divider_select),
    .done(settle_done)
  );

  // ****************************************************************
  // Registered controls toward the chip
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      power_state <= spc_pkg::SPC_RESET;
      osc_enable <= 1'b1;
      clock_supply <= 1'b1;
      cpu_halt <= 1'b1;
      chip_reset <= 1'b1;
      port_hold <= 1'b0;
      port_hiz <= 1'b0;
    end else if (clk_en) begin
      power_state <= next_state;
      osc_enable <= (next_state != spc_pkg::SPC_SW_STANDBY_PIN) &&
                    (next_state != spc_pkg::SPC_HW_STANDBY_PIN);
      clock_supply <= (next_state == spc_pkg::SPC_RUN) || (next_state == spc_pkg::SPC_SLEEP) ||
                      (next_state == spc_pkg::SPC_RESET);
      cpu_halt <= next_state != spc_pkg::SPC_RUN;
      chip_reset <= (next_state == spc_pkg::SPC_HW_STANDBY_PIN) ||
                    (next_state == spc_pkg::SPC_RESET);
      port_hold <= (next_state == spc_pkg::SPC_SW_STANDBY_PIN) ||
                   (next_state == spc_pkg::SPC_SETTLE);
      port_hiz <= next_state == spc_pkg::SPC_HW_STANDBY_PIN;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      int_exception <= 1'b0;
      reset_exception <= 1'b0;
    end else if (clk_en) begin
      int_exception <= ((state == spc_pkg::SPC_SETTLE) || (state == spc_pkg::SPC_SLEEP)) &&
                       (next_state == spc_pkg::SPC_RUN);
      reset_exception <= (state == spc_pkg::SPC_RESET) &&
                         (next_state == spc_pkg::SPC_RUN);
    end
  end

  // Mode pins are caught as reset handling starts, so later changes have no effect.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_latched <= 3'h0;
    end else if (clk_en) begin
      if ((state == spc_pkg::SPC_RESET) && (next_state == spc_pkg::SPC_RUN)) begin
        mode_latched <= mode_s;
      end
    end
  end

  // ****************************************************************
  // System clock output pin
  // ****************************************************************
  // In run, sleep and reset the pin carries core_clk divided by two so that it leaves a flip-flop; software standby and settling hold it high.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      clkout_o <= 1'b0;
      clkout_oe <= 1'b0;
    end else if (clk_en) begin
      if (clock_output_stop || (next_state == spc_pkg::SPC_HW_STANDBY_PIN)) begin
        clkout_oe <= 1'b0;
        clkout_o <= 1'b0;
      end else if ((next_state == spc_pkg::SPC_SW_STANDBY_PIN) ||
                   (next_state == spc_pkg::SPC_SETTLE)) begin
        clkout_oe <= 1'b1;
        clkout_o <= 1'b1;
      end else begin
        clkout_oe <= 1'b1;
        clkout_o <= !clkout_o;
      end
    end
  end

endmodule : spc_standby_power_control

// ===== testbench/spc_checker.sv
// Port-level assertions for the standby power control block.
`timescale 1ns/100ps
module spc_checker (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire spc_pkg::spc_bus_req_t bus_req,
  input wire logic [7:0] bus_rdata,
  input wire logic reset_pin_b,
  input wire logic standby_pin_b,
  input wire logic [3:0] periph_hit,
  input wire spc_pkg::spc_state_t power_state,
  input wire logic osc_enable,
  input wire logic clock_supply,
  input wire logic cpu_halt,
  input wire logic chip_reset,
  input wire logic int_exception,
  input wire logic reset_exception,
  input wire logic port_hold,
  input wire logic port_hiz,
  input wire logic [3:0] module_standby,
  input wire logic [3:0] module_init,
  input wire logic clkout_o,
  input wire logic clkout_oe
);
  // *****************************************
  // Assertions
  // *****************************************
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  property p_hw;
    power_state == spc_pkg::SPC_HW_STANDBY_PIN |->
      port_hiz && !clkout_oe && chip_reset && module_init == 4'hf;
  endproperty
  a_hw: assert property (p_hw) else $error("hw standby outputs wrong");
  property p_sw;
    power_state == spc_pkg::SPC_SW_STANDBY_PIN |-> port_hold && cpu_halt && !osc_enable;
  endproperty
  a_sw: assert property (p_sw) else $error("sw standby outputs wrong");
  property p_clk;
    power_state == spc_pkg::SPC_SW_STANDBY_PIN && clkout_oe |-> clkout_o;
  endproperty
  a_clk: assert property (p_clk) else $error("clock pin not high");
  property p_int;
    $past(power_state) == spc_pkg::SPC_SETTLE && power_state == spc_pkg::SPC_RUN |->
      int_exception ##1 !int_exception;
  endproperty
  a_int: assert property (p_int) else $error("interrupt start wrong");
  property p_rx;
    reset_exception |-> $past(power_state) == spc_pkg::SPC_RESET ##1 !reset_exception;
  endproperty
  a_rx: assert property (p_rx) else $error("reset start wrong");
  property p_standby_pin;
    $fell(standby_pin_b) |-> ##[1:4] power_state == spc_pkg::SPC_HW_STANDBY_PIN;
  endproperty
  a_standby_pin: assert property (p_standby_pin) else $error("no hw standby");
  property p_rwake;
    $fell(reset_pin_b) && standby_pin_b |->
      ##[1:4] power_state == spc_pkg::SPC_RESET && clock_supply && osc_enable;
  endproperty
  a_rwake: assert property (p_rwake) else $error("reset pin not obeyed");
  property p_mod;
    logic [7:0] d;
    logic [3:0] o;
    (clk_en && bus_req.wr && bus_req.addr == spc_pkg::MODSTOP_ADDR && power_state == spc_pkg::SPC_RUN,
      d = bus_req.wdata, o = module_standby) |=>
      module_standby == {d[5], d[4], d[3], d[0]} && module_init == (module_standby & ~o);
  endproperty
  a_mod: assert property (p_mod) else $error("module stop wrong");
  property p_ff;
    clk_en && bus_req.rd && (periph_hit & module_standby) != 4'h0 |=> bus_rdata == spc_pkg::STOPPED_PERIPH_DATA;
  endproperty
  a_ff: assert property (p_ff) else $error("stopped read not ff");
endmodule : spc_checker
bind spc_standby_power_control spc_checker u_chk (.core_clk, .rst_b, .clk_en, .bus_req, .bus_rdata,
  .reset_pin_b, .standby_pin_b, .periph_hit, .power_state, .osc_enable, .clock_supply, .cpu_halt,
  .chip_reset, .int_exception, .reset_exception, .port_hold, .port_hiz, .module_standby,
  .module_init, .clkout_o, .clkout_oe);

// ===== testbench/spc_pin_model.sv
// Board-side driver of the reset, standby, interrupt and mode pins.
`timescale 1ns/100ps
module spc_pin_model (
  input wire logic core_clk,
  output logic reset_pin_b,
  output logic standby_pin_b,
  output logic nmi_pin,
  output logic ext_request_0_b,
  output logic ext_request_1_b,
  output logic [2:0] operating_mode_pins
);
  // *****************************************
  // Pin sequences
  // *****************************************
  initial begin
    reset_pin_b = 1'b1;
    standby_pin_b = 1'b1;
    nmi_pin = 1'b1;
    ext_request_0_b = 1'b1;
    ext_request_1_b = 1'b1;
    operating_mode_pins = 3'h0;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wait_cyc
  task automatic set_nmi(input logic v);
    @(posedge core_clk);
    nmi_pin <= v;
    wait_cyc(6);
  endtask : set_nmi
  // Requests are levels, so they are held well past the pin synchronisers.
  task automatic fire(input int src, input logic rise);
    @(posedge core_clk);
    if (src == 2) nmi_pin <= rise;
    else if (src == 1) ext_request_1_b <= 1'b0;
    else ext_request_0_b <= 1'b0;
    wait_cyc(6);
    ext_request_0_b <= 1'b1;
    ext_request_1_b <= 1'b1;
  endtask : fire
  task automatic rst_cycle(input int hold);
    @(posedge core_clk);
    reset_pin_b <= 1'b0;
    wait_cyc(hold);
    reset_pin_b <= 1'b1;
    wait_cyc(4);
  endtask : rst_cycle
  // Mode pins move only before entry, never while the chip sleeps.
  task automatic standby_pin_cycle(input logic with_rst, input logic [2:0] mode);
    @(posedge core_clk);
    operating_mode_pins <= mode;
    wait_cyc(4);
    if (with_rst) reset_pin_b <= 1'b0;
    wait_cyc(6);
    standby_pin_b <= 1'b0;
    wait_cyc(10);
    standby_pin_b <= 1'b1;
    wait_cyc(10);
    reset_pin_b <= 1'b1;
    wait_cyc(16);
  endtask : standby_pin_cycle
endmodule : spc_pin_model

// ===== testbench/spc_standby_power_control_tb.sv
// Self-checking bench for the standby power control block.
`timescale 1ns/100ps
module spc_standby_power_control_tb;
  localparam int W[6] = '{8, 16, 32, 64, 128, 4};
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  spc_pkg::spc_bus_req_t bus_req = '0;
  logic halt_request = 1'b0;
  logic [1:0] irq_enable = 2'h3;
  logic irq_masked = 1'b0;
  logic sleep_wake_request = 1'b0;
  logic [3:0] periph_hit = 4'h0;
  logic reset_pin_b, standby_pin_b, nmi_pin, ext_request_0_b, ext_request_1_b;
  logic [2:0] operating_mode_pins, mode_latched;
  logic [7:0] bus_rdata, d;
  spc_pkg::spc_state_t power_state;
  logic osc_enable, clock_supply, cpu_halt, chip_reset, int_exception, reset_exception;
  logic port_hold, port_hiz, ram_enable, clkout_o, clkout_oe, rd_d = 1'b0;
  logic [3:0] module_standby, module_init;
  logic [15:0] ra[3] = '{spc_pkg::SYSCTL_ADDR, spc_pkg::MODSTOP_ADDR, spc_pkg::DIVCTL_ADDR};
  logic [7:0] rm[3] = '{spc_pkg::SYSCTL_WMASK, spc_pkg::MODSTOP_WMASK, spc_pkg::DIVCTL_WMASK};
  logic [7:0] rr[3] = '{spc_pkg::SYSCTL_RESET, spc_pkg::MODSTOP_RESET, spc_pkg::DIVCTL_RESET};
  logic [7:0] exp_q[$];
  int err_count = 0;
  int cmp_count = 0;
  int seed = 71;
  int j, n, m;
  always #20 core_clk = ~core_clk;
  spc_pin_model pm (.core_clk, .reset_pin_b, .standby_pin_b, .nmi_pin, .ext_request_0_b,
    .ext_request_1_b, .operating_mode_pins);
  spc_standby_power_control #(.WAIT_0(W[0]), .WAIT_1(W[1]), .WAIT_2(W[2]), .WAIT_3(W[3]),
    .WAIT_4(W[4]), .WAIT_5(W[5])) DUT (.core_clk, .rst_b, .clk_en, .bus_req, .bus_rdata,
    .reset_pin_b, .standby_pin_b, .nmi_pin, .ext_request_0_b, .ext_request_1_b,
    .operating_mode_pins, .halt_request, .irq_enable, .irq_masked, .sleep_wake_request,
    .periph_hit, .power_state, .osc_enable, .clock_supply, .cpu_halt, .chip_reset,
    .int_exception, .reset_exception, .port_hold, .port_hiz, .ram_enable, .module_standby,
    .module_init, .clkout_o, .clkout_oe, .mode_latched);
  // *****************************************
  // Tasks
  // *****************************************
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Reads queue their expected data for the watcher.
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] v);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: v, wr: w, rd: !w};
    if (!w) exp_q.push_back(v);
    @(posedge core_clk);
    bus_req <= '0;
  endtask : bus
  task automatic halt(input logic [7:0] sys);
    bus(1'b1, spc_pkg::SYSCTL_ADDR, sys);
    @(posedge core_clk);
    halt_request <= 1'b1;
    @(posedge core_clk);
    halt_request <= 1'b0;
    bus(1'b0, spc_pkg::STATUS_ADDR, sys[7] ? 8'h04 : 8'h02);
  endtask : halt
  task automatic settle_len(output int cnt);
    cnt = 0;
    for (int k = 0; k < 60 && power_state !== spc_pkg::SPC_SETTLE; k++) @(negedge core_clk);
    chk("osc", osc_enable, 1'b1);
    while (power_state === spc_pkg::SPC_SETTLE && cnt < 2000) begin
      cnt++;
      @(negedge core_clk);
    end
  endtask : settle_len
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  always @(posedge core_clk) rd_d <= bus_req.rd;
  always @(negedge core_clk) if (rd_d) chk("rdata", bus_rdata, exp_q.pop_front());
  initial begin
    repeat (40000) @(posedge core_clk);
    err_count++;
    complete_run();
  end
  // *****************************************
  // Scenarios
  // *****************************************
  initial begin
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    for (j = 0; j < 3; j++) bus(1'b0, ra[j], rr[j]);
    bus(1'b0, 16'h1234, spc_pkg::UNMAPPED_DATA);
    for (j = 0; j < 6; j++) begin
      d = 8'($random(seed));
      bus(1'b1, ra[j % 3], d);
      bus(1'b0, ra[j % 3], (d & rm[j % 3]) | (rr[j % 3] & ~rm[j % 3]));
    end
    $display("test registers done");
    for (j = 0; j < 4; j++) begin
      d = (j != 0) ? 8'h04 << j : 8'h01;
      bus(1'b1, spc_pkg::MODSTOP_ADDR, 8'h00);
      bus(1'b1, spc_pkg::MODSTOP_ADDR, d);
      @(negedge core_clk);
      chk("init", module_init, 4'h1 << j);
      chk("stop", module_standby, 4'h1 << j);
      @(posedge core_clk);
      periph_hit <= 4'h1 << j;
      bus(1'b0, 16'hff60, 8'hff);
      periph_hit <= 4'h1 << ((j + 1) % 4);
      bus(1'b0, 16'hff60, 8'h00);
      periph_hit <= 4'h0;
    end
    bus(1'b1, spc_pkg::MODSTOP_ADDR, 8'h80);
    repeat (2) @(negedge core_clk);
    chk("clk_oe", clkout_oe, 1'b0);
    bus(1'b1, spc_pkg::MODSTOP_ADDR, 8'h00);
    repeat (2) @(negedge core_clk);
    chk("clk_oe", clkout_oe, 1'b1);
    $display("test module standby done");
    halt(8'h09);
    @(posedge core_clk);
    sleep_wake_request <= 1'b1;
    @(posedge core_clk);
    sleep_wake_request <= 1'b0;
    bus(1'b0, spc_pkg::STATUS_ADDR, 8'h01);
    for (j = 0; j < 7; j++) begin
      n = ((j == 6) ? W[4] : W[j]) << (j % 4);
      d = {1'b1, (j == 6) ? 3'h7 : 3'(j), 1'b0, j[0], 2'b01};
      bus(1'b1, spc_pkg::DIVCTL_ADDR, 8'(j % 4));
      if (j % 3 == 2) pm.set_nmi(!j[0]);
      halt(d);
      fork
        pm.fire(j % 3, j[0]);
        settle_len(m);
      join
      chk("settle", m, n + 1);
      bus(1'b0, spc_pkg::SYSCTL_ADDR, d | 8'h0a);
    end
    $display("test interrupt wake done");
    halt(8'h81);
    irq_enable <= 2'h0;
    pm.fire(0, 1'b0);
    repeat (4) @(posedge core_clk);
    irq_enable <= 2'h3;
    irq_masked <= 1'b1;
    pm.fire(1, 1'b0);
    repeat (4) @(posedge core_clk);
    sleep_wake_request <= 1'b1;
    @(posedge core_clk);
    sleep_wake_request <= 1'b0;
    bus(1'b0, spc_pkg::STATUS_ADDR, 8'h04);
    pm.rst_cycle(8);
    irq_masked <= 1'b0;
    bus(1'b0, spc_pkg::STATUS_ADDR, 8'h01);
    $display("test blocked wake done");
    halt(8'h80);
    pm.standby_pin_cycle(1'b0, 3'h5);
    chk("mode", mode_latched, 3'h5);
    chk("ram", ram_enable, 1'b1);
    bus(1'b0, spc_pkg::SYSCTL_ADDR, spc_pkg::SYSCTL_RESET);
    bus(1'b1, spc_pkg::MODSTOP_ADDR, 8'hb9);
    pm.standby_pin_cycle(1'b1, 3'h2);
    chk("mode", mode_latched, 3'h2);
    bus(1'b0, spc_pkg::MODSTOP_ADDR, spc_pkg::MODSTOP_RESET);
    $display("test hardware standby done");
    complete_run();
  end
endmodule : spc_standby_power_control_tb
